// [src/tfa_defs.svh]
// Purpose: shared constants of the tape format adapter
// Assumes: system clock of 40 MHz (25 ns)
// Notes:   times are kept in their own unit; cycle counts derive from them
//
// Operation
// R01: up to seven tape units, each addressable
// R02: host commands any one unit separately
// R03: serialize host words, deserialize tape data
// R04: adapter makes every tape timing pulse
// R05: output path: 30 bits, request, acknowledge, function
// R06: input path: 30 bits, request, acknowledge, interrupt
// R07: demand-in reaches only the addressed unit
// R08: return data, not-ready taken from addressed unit
// R09: all other tape lines go to every unit
// R10: tape-side signals are pulses, not levels
// R11: 6 us base, half-offset, 42 us, 5.04 ms
// R12: 7-bit unit address from latest function
// R13: 30-bit assembly register, 6-bit character register
// R14: buffer words between host and assembly register
// R15: pulses from system clock, fixed width, sync reset
`ifndef TFA_DEFS_SVH
`define TFA_DEFS_SVH

// clock and pulse timing
`define TFA_CLK_NS          25
`define TFA_BASE_NS         6000
`define TFA_OFFSET_NS       3000
`define TFA_CHAR_FRAME_NS   42000
`define TFA_LONG_FRAME_NS   5040000
`define TFA_PULSE_MIN_NS    750
`define TFA_PULSE_MAX_NS    1000
`define TFA_BASE_CYC        (`TFA_BASE_NS / `TFA_CLK_NS)
`define TFA_OFFSET_CYC      (`TFA_OFFSET_NS / `TFA_CLK_NS)
`define TFA_SLOTS           (`TFA_CHAR_FRAME_NS / `TFA_BASE_NS)
`define TFA_LONG_FRAMES     (`TFA_LONG_FRAME_NS / `TFA_CHAR_FRAME_NS)
`define TFA_LONG_SLOT       6
// width sits mid-window so both bounds are kept with margin
`define TFA_PULSE_CYC       ((`TFA_PULSE_MIN_NS + `TFA_PULSE_MAX_NS) / (2 * `TFA_CLK_NS))

// word layout
`define TFA_UNITS           7
`define TFA_WORD_BITS       30
`define TFA_CHAR_BITS       6
`define TFA_CHARS_PER_WORD  5

// adapter instruction codes in the function word
`define TFA_OP_NONE         2'h0
`define TFA_OP_IN           2'h1
`define TFA_OP_OUT          2'h2

// status word sent with an interrupt
`define TFA_STAT_NR_BIT     29

`endif

// [src/tfa_pkg.sv]
// Purpose: types of the tape format adapter
// Assumes: nothing
// Notes:   constants live in tfa_defs.svh
package tfa_pkg;

    // sequencer state, one-hot
    typedef enum logic [2:0] {
        TFA_IDLE  = 3'b001,
        TFA_WRITE = 3'b010,
        TFA_READ  = 3'b100
    } tfa_state_e;

    // timing pulse trains to all units
    typedef struct packed {
        logic long_frame_pulse;
        logic char_frame_pulse;
        logic offset_pulse;
        logic base_pulse;
    } tfa_timing_s;

    // function command word layout
    typedef struct packed {
        logic [14:0] spare;
        logic        master_clear;
        logic        avail;
        logic [1:0]  op;
        logic [6:0]  addr;
        logic [3:0]  instr;
    } tfa_func_s;

endpackage

// [src/tfa_sync.sv]
// Purpose: two-flop synchroniser for a bus of independent levels
// Assumes: each bit is a level or a toggle, never a multi-bit word
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module tfa_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);
    logic [W-1:0] meta; // first stage, read by q only

    // plain two-stage capture, no reset needed for metastability guard
    always_ff @(posedge clk) begin
        meta <= d;
        q    <= meta;
    end
endmodule // tfa_sync
`default_nettype wire

// [src/tfa_timebase.sv]
// Purpose: free-running timebase for the tape pulse trains
// Assumes: clk is the system clock; reset is synchronous
// Notes:   emits one-cycle strobes; stretching is done by the caller
`timescale 1ns/1ps
`default_nettype none
`include "tfa_defs.svh"
module tfa_timebase #(
    parameter int BASE_CYC    = `TFA_BASE_CYC,
    parameter int OFFSET_CYC  = `TFA_OFFSET_CYC,
    parameter int SLOTS       = `TFA_SLOTS,
    parameter int LONG_FRAMES = `TFA_LONG_FRAMES
) (
    input  wire logic           clk,
    input  wire logic           rst,
    output tfa_pkg::tfa_timing_s stb,
    output logic [2:0]          slot
);
    localparam int CW = $clog2(BASE_CYC);
    localparam int FW = $clog2(LONG_FRAMES);

    logic [CW-1:0] cyc;   // cycle within one base period
    logic [FW-1:0] frame; // char frame within a long frame
    logic          wrap;  // last cycle of a base period
    logic          last_slot;
    logic [2:0]    next_slot;

    assign wrap      = (cyc == CW'(BASE_CYC - 1));
    assign last_slot = (slot == 3'(SLOTS));
    assign next_slot = last_slot ? 3'h1 : slot + 3'h1;

    // period counter; slot moves ahead so it is current at cycle zero
    always_ff @(posedge clk) begin
        if (rst) begin // R15
            cyc   <= '0;
            slot  <= 3'h1;
            frame <= '0;
        end else begin
            cyc <= wrap ? '0 : cyc + CW'(1);
            if (wrap) begin
                slot <= next_slot;
                if (last_slot) begin
                    frame <= (frame == FW'(LONG_FRAMES - 1)) ? '0 : frame + FW'(1);
                end
            end
        end
    end

    // strobes: base at cycle 0, offset half a period later
    always_ff @(posedge clk) begin
        if (rst) begin
            stb <= '0;
        end else begin
            stb.base_pulse       <= (cyc == '0); // R11
            stb.offset_pulse     <= (cyc == CW'(OFFSET_CYC)); // R11
            stb.char_frame_pulse <= (cyc == '0) && (slot == 3'h1); // R11
            // long frame on slot 6 of the last frame, two slots before frame start
            stb.long_frame_pulse <= (cyc == '0) && (slot == 3'(`TFA_LONG_SLOT))
                                    && (frame == FW'(LONG_FRAMES - 1)); // R11
        end
    end
endmodule // tfa_timebase
`default_nettype wire

// [src/tfa_format_adapter.sv]
// Purpose: adapter between host word channels and serial tape units
// Assumes: host channel logic on chan_clk; tape side on clk (40 MHz)
// Notes:   one word in each direction is handed across by toggle handshake
`timescale 1ns/1ps
`default_nettype none
`include "tfa_defs.svh"
module tfa_format_adapter #(
    parameter int LONG_FRAMES = `TFA_LONG_FRAMES,
    parameter int PULSE_W     = `TFA_PULSE_CYC
) (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        chan_clk,
    // host output channel
    input  wire logic [`TFA_WORD_BITS-1:0]   out_info,
    input  wire logic                        ext_func,
    input  wire logic                        out_ack,
    output logic                             out_data_req,
    // host input channel
    output logic [`TFA_WORD_BITS-1:0]        in_info,
    output logic                             in_data_req,
    input  wire logic                        in_ack,
    output logic                             interrupt,
    // tape side
    input  wire logic [`TFA_UNITS-1:0]       tape_ones_in,
    input  wire logic [`TFA_UNITS-1:0]       tape_not_ready,
    output tfa_pkg::tfa_timing_s             timing,
    output logic [3:0]                       tape_instr,
    output logic [`TFA_UNITS-1:0]            demand_in,
    output logic                             demand_clear,
    output logic                             master_clear,
    output logic                             ser_ones,
    output logic                             ser_zeros
);
    localparam int U  = `TFA_UNITS;
    localparam int WB = `TFA_WORD_BITS;
    localparam int CB = `TFA_CHAR_BITS;
    localparam int NL = 4 + 4 + U + 4;   // stretched tape lines
    localparam int PW = $clog2(PULSE_W + 1);

    ////////////////////////////////////////////////////////////////////////
    // chan domain: reset and crossings in
    ////////////////////////////////////////////////////////////////////////
    logic             rst_c;        // reset seen on chan_clk
    logic [2:0]       to_chan_s;    // synced: word taken, in word, interrupt
    logic             wtake_s_c;
    logic             inw_s_c;
    logic             int_s_c;
    logic             wtake_q_c;    // previous toggle values
    logic             inw_q_c;
    logic             int_q_c;

    tfa_sync #(.W(1)) u_rst_c (
        .clk (chan_clk),
        .d   (rst),
        .q   (rst_c)
    );

    // toggles from the tape side (driven further down)
    logic             wtake_tgl;
    logic             inw_tgl;
    logic             int_tgl;

    tfa_sync #(.W(3)) u_to_chan (
        .clk (chan_clk),
        .d   ({int_tgl, inw_tgl, wtake_tgl}),
        .q   (to_chan_s)
    );
    assign wtake_s_c = to_chan_s[0];
    assign inw_s_c   = to_chan_s[1];
    assign int_s_c   = to_chan_s[2];

    ////////////////////////////////////////////////////////////////////////
    // chan domain: communication register and host handshakes
    ////////////////////////////////////////////////////////////////////////
    tfa_pkg::tfa_func_s      func_hold;  // latest function word
    logic [WB-1:0]           c_out;      // output word waiting for Z
    logic                    c_out_full;
    logic                    func_tgl;   // function handed to tape side
    logic                    word_tgl;   // output word handed to tape side
    logic                    indone_tgl; // input word accepted by host
    logic                    int_pend;   // interrupt waiting for free channel
    logic [WB-1:0]           in_word;    // assembled word from tape side
    logic                    next_full;
    logic                    wtake_ev_c;
    logic                    inw_ev_c;
    logic                    int_ev_c;
    logic                    op_out_c;

    assign wtake_ev_c = wtake_s_c ^ wtake_q_c;
    assign inw_ev_c   = inw_s_c ^ inw_q_c;
    assign int_ev_c   = int_s_c ^ int_q_c;
    assign op_out_c   = (func_hold.op == `TFA_OP_OUT);
    // new word in wins over the slot freeing in the same cycle
    assign next_full  = (out_ack && out_data_req) || (c_out_full && !wtake_ev_c);

    // function capture and output word buffer
    always_ff @(posedge chan_clk) begin
        if (rst_c) begin
            func_hold    <= '0;
            func_tgl     <= 1'b0;
            c_out        <= '0;
            c_out_full   <= 1'b0;
            word_tgl     <= 1'b0;
            out_data_req <= 1'b0;
            wtake_q_c    <= 1'b0;
        end else begin
            wtake_q_c <= wtake_s_c;
            if (ext_func) begin // R05
                func_hold <= tfa_pkg::tfa_func_s'(out_info); // R12
                func_tgl  <= ~func_tgl;
            end
            if (out_ack && out_data_req) begin // R05 R14
                c_out    <= out_info;
                word_tgl <= ~word_tgl;
            end
            c_out_full   <= next_full;
            // ask for the next word only while writing and C is empty
            out_data_req <= op_out_c && !next_full && !ext_func;
        end
    end

    // input word and interrupt towards the host
    always_ff @(posedge chan_clk) begin
        if (rst_c) begin
            in_info     <= '0;
            in_data_req <= 1'b0;
            interrupt   <= 1'b0;
            int_pend    <= 1'b0;
            indone_tgl  <= 1'b0;
            inw_q_c     <= 1'b0;
            int_q_c     <= 1'b0;
        end else begin
            inw_q_c   <= inw_s_c;
            int_q_c   <= int_s_c;
            interrupt <= 1'b0;
            if (in_ack && in_data_req) begin // R06
                in_data_req <= 1'b0;
                indone_tgl  <= ~indone_tgl;
            end else if (inw_ev_c) begin // R06 R14
                in_info     <= in_word;
                in_data_req <= 1'b1;
            end else if (int_pend || int_ev_c) begin
                // status word goes out only while the channel is free
                if (!in_data_req) begin // R06
                    in_info                   <= '0;
                    in_info[`TFA_STAT_NR_BIT] <= 1'b1;
                    in_info[U-1:0]            <= func_hold.addr;
                    interrupt                 <= 1'b1;
                    int_pend                  <= 1'b0;
                end else begin
                    int_pend <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // tape domain: synchronisers and timebase
    ////////////////////////////////////////////////////////////////////////
    logic [2*U-1:0]          tape_s;     // synced tape returns
    logic [2:0]              from_chan_s;
    logic                    func_s;
    logic                    word_s;
    logic                    indone_s;
    tfa_pkg::tfa_timing_s    tstb;       // one-cycle timing strobes
    logic [2:0]              slot;       // 1..7 within a char frame

    tfa_sync #(.W(2*U)) u_tape_in (
        .clk (clk),
        .d   ({tape_not_ready, tape_ones_in}),
        .q   (tape_s)
    );

    tfa_sync #(.W(3)) u_from_chan (
        .clk (clk),
        .d   ({indone_tgl, word_tgl, func_tgl}),
        .q   (from_chan_s)
    );
    assign func_s   = from_chan_s[0];
    assign word_s   = from_chan_s[1];
    assign indone_s = from_chan_s[2];

    tfa_timebase #(.LONG_FRAMES(LONG_FRAMES)) u_timebase (
        .clk  (clk),
        .rst  (rst),
        .stb  (tstb), // R04 R11
        .slot (slot)
    );

    ////////////////////////////////////////////////////////////////////////
    // tape domain: unit selection and decode
    ////////////////////////////////////////////////////////////////////////
    tfa_pkg::tfa_state_e     state;
    logic [U-1:0]            addr;       // selected unit, one bit per unit
    logic                    func_q;
    logic                    word_q;
    logic                    indone_q;
    logic                    func_ev;
    logic                    word_ev;
    logic                    sel_ones;
    logic                    sel_nr;
    logic                    sel_ones_q;
    logic                    sel_nr_q;
    logic                    data_slot;  // slots 1..6 carry bits

    assign func_ev   = func_s ^ func_q;
    assign word_ev   = word_s ^ word_q;
    // returns gated by the address; other units are ignored
    assign sel_ones  = |(tape_s[U-1:0] & addr); // R08
    assign sel_nr    = |(tape_s[2*U-1:U] & addr); // R08
    assign data_slot = (slot != 3'h0) && (slot <= 3'(CB));

    ////////////////////////////////////////////////////////////////////////
    // tape domain: sequencer, Z and X registers
    ////////////////////////////////////////////////////////////////////////
    logic [WB-1:0]           z;          // assembly register
    logic [CB-1:0]           x;          // character register
    logic                    z_valid;    // write: Z holds unsent chars
    logic                    bit_active; // write: char in flight
    logic [2:0]              char_cnt;
    logic                    seen;       // ones pulse seen this bit time
    logic                    in_busy;    // host still owns the last word
    logic                    bit_val;
    logic [CB-1:0]           new_char;
    logic                    ser1_stb;
    logic                    ser0_stb;
    logic                    write_bit;
    logic                    load_char;

    assign load_char = (state == tfa_pkg::TFA_WRITE) && tstb.base_pulse
                       && (slot == 3'h1) && z_valid;
    assign write_bit = (state == tfa_pkg::TFA_WRITE) && tstb.base_pulse && data_slot
                       && (bit_active || load_char);
    assign bit_val   = load_char ? z[WB-1] : x[CB-1];
    assign ser1_stb  = write_bit && bit_val; // R03 R10
    assign ser0_stb  = write_bit && !bit_val; // R03 R10
    assign new_char  = {x[CB-2:0], seen};

    // mode, address and toggle bookkeeping
    always_ff @(posedge clk) begin
        if (rst) begin
            state      <= tfa_pkg::TFA_IDLE;
            addr       <= '0;
            func_q     <= 1'b0;
            indone_q   <= 1'b0;
            sel_ones_q <= 1'b0;
            sel_nr_q   <= 1'b0;
            int_tgl    <= 1'b0;
            seen       <= 1'b0;
        end else begin
            func_q     <= func_s;
            indone_q   <= indone_s;
            sel_ones_q <= sel_ones;
            sel_nr_q   <= sel_nr;
            if (func_ev) begin
                addr <= func_hold.addr; // R01 R02 R12
                case (func_hold.op)
                    `TFA_OP_IN:  state <= tfa_pkg::TFA_READ;
                    `TFA_OP_OUT: state <= tfa_pkg::TFA_WRITE;
                    default:     state <= tfa_pkg::TFA_IDLE;
                endcase
            end
            // not-ready edge from the selected unit raises an interrupt
            if (sel_nr && !sel_nr_q) begin
                int_tgl <= ~int_tgl;
            end
            // a new pulse wins over the mid-bit sample that clears
            if (sel_ones && !sel_ones_q) begin // R10
                seen <= 1'b1;
            end else if (tstb.offset_pulse) begin
                seen <= 1'b0;
            end
        end
    end

    // assembly and disassembly
    always_ff @(posedge clk) begin
        if (rst) begin
            z          <= '0;
            x          <= '0;
            z_valid    <= 1'b0;
            bit_active <= 1'b0;
            char_cnt   <= 3'h0;
            word_q     <= 1'b0;
            wtake_tgl  <= 1'b0;
            inw_tgl    <= 1'b0;
            in_word    <= '0;
            in_busy    <= 1'b0;
        end else begin
            if (indone_s ^ indone_q) begin
                in_busy <= 1'b0;
            end
            if (func_ev) begin
                z_valid    <= 1'b0;
                bit_active <= 1'b0;
                char_cnt   <= 3'h0;
            end else if (state == tfa_pkg::TFA_WRITE) begin
                // C to Z only once Z is empty, then free C
                if (word_ev && !z_valid) begin // R14
                    z         <= c_out;
                    z_valid   <= 1'b1;
                    char_cnt  <= 3'h0;
                    word_q    <= word_s;
                    wtake_tgl <= ~wtake_tgl;
                end else if (load_char) begin // R13
                    x          <= {z[WB-2:WB-CB], 1'b0};
                    z          <= {z[WB-CB-1:0], {CB{1'b0}}};
                    bit_active <= 1'b1;
                    char_cnt   <= char_cnt + 3'h1;
                    if (char_cnt == 3'(`TFA_CHARS_PER_WORD - 1)) begin
                        z_valid <= 1'b0;
                    end
                end else if (write_bit) begin
                    x <= {x[CB-2:0], 1'b0};
                    if (slot == 3'(CB)) begin
                        bit_active <= 1'b0;
                    end
                end
            end else if (state == tfa_pkg::TFA_READ) begin
                if (tstb.offset_pulse && data_slot) begin // R03
                    x <= new_char;
                    if (slot == 3'(CB)) begin // R13
                        z <= {z[WB-CB-1:0], new_char};
                        if (char_cnt == 3'(`TFA_CHARS_PER_WORD - 1)) begin
                            char_cnt <= 3'h0;
                            // a word finished while the host lags is dropped
                            if (!in_busy) begin // R14
                                in_word <= {z[WB-CB-1:0], new_char};
                                inw_tgl <= ~inw_tgl;
                                in_busy <= 1'b1;
                            end
                        end else begin
                            char_cnt <= char_cnt + 3'h1;
                        end
                    end
                end
            end
            if (state != tfa_pkg::TFA_WRITE) begin
                word_q <= word_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // tape domain: fixed-width pulse lines
    ////////////////////////////////////////////////////////////////////////
    logic [NL-1:0]           line_stb;   // one-cycle requests
    logic [NL-1:0]           line_q;     // stretched, drives the pins
    logic [3:0]              instr_stb;
    logic [U-1:0]            demand_stb;

    assign instr_stb  = func_ev ? func_hold.instr : 4'h0; // R09
    // demand-in goes to the addressed unit alone
    assign demand_stb = (func_ev && (func_hold.instr != 4'h0)) ? func_hold.addr : '0; // R07
    assign line_stb   = {ser0_stb, ser1_stb,
                         func_ev && func_hold.master_clear,
                         func_ev && (func_hold.instr == 4'h0),
                         demand_stb, instr_stb, tstb};

    // each line holds high for PULSE_W cycles after its strobe
    generate
        for (genvar i = 0; i < NL; i++) begin : g_line
            logic [PW-1:0] cnt;
            logic [PW-1:0] next_cnt;
            assign next_cnt = line_stb[i] ? PW'(PULSE_W)
                            : (cnt != '0) ? cnt - PW'(1) : '0;
            always_ff @(posedge clk) begin
                if (rst) begin // R15
                    cnt       <= '0;
                    line_q[i] <= 1'b0;
                end else begin
                    cnt       <= next_cnt;
                    line_q[i] <= (next_cnt != '0); // R10 R15
                end
            end
        end
    endgenerate

    // all lines but demand_in fan out to every unit
    assign timing       = line_q[3:0]; // R04 R09
    assign tape_instr   = line_q[7:4]; // R09
    assign demand_in    = line_q[8+U-1:8];
    assign demand_clear = line_q[8+U];
    assign master_clear = line_q[9+U];
    assign ser_ones     = line_q[10+U];
    assign ser_zeros    = line_q[11+U];

endmodule // tfa_format_adapter
`default_nettype wire

// [testbench/tfa_tape_model.sv]
// Purpose: behavioural tape unit bank at the far side
// Assumes: pulses are launched on the falling clock edge
// Notes:   idle lines sit low; only pulses carry events
`timescale 1ns/1ps
`default_nettype none
module tfa_tape_model (
    input  wire logic  clk,
    output logic [6:0] ones,
    output logic [6:0] not_ready
);
    initial begin
        ones = '0;
        not_ready = '0;
    end
    // one not-ready pulse of standard width on unit u
    task automatic nr_pulse(input int u);
        @(negedge clk) not_ready[u] = 1'b1;
        repeat (35) @(negedge clk);
        not_ready[u] = 1'b0;
    endtask
endmodule // tfa_tape_model
`default_nettype wire

// [testbench/tfa_format_adapter_checker.sv]
// Purpose: port assertions of the format adapter
// Assumes: 240-cycle base slot, 120-cycle offset
// Notes:   host side is judged on chan_clk
`timescale 1ns/1ps
`default_nettype none
module tfa_checker #(parameter int PULSE_W = 35) (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic                 chan_clk,
    input wire tfa_pkg::tfa_timing_s timing,
    input wire logic [6:0]           demand_in,
    input wire logic                 ser_ones,
    input wire logic                 ser_zeros,
    input wire logic                 interrupt,
    input wire logic [29:0]          in_info
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // start of a base slot
    sequence s_base;
        $rose(timing.base_pulse);
    endsequence
    a_unit_select: assert property ($onehot0(demand_in)) else $error("demand to several units");
    a_pulse_width: assert property (s_base |-> ##(PULSE_W-1) timing.base_pulse ##1 !timing.base_pulse)
        else $error("pulse width wrong");
    a_base_period: assert property (s_base |-> ##240 s_base) else $error("base period wrong");
    a_offset_gap: assert property (s_base |-> ##120 $rose(timing.offset_pulse))
        else $error("offset gap wrong");
    a_char_align: assert property ($rose(timing.char_frame_pulse) |-> s_base)
        else $error("char frame off base");
    a_long_align: assert property ($rose(timing.long_frame_pulse) |-> s_base)
        else $error("long frame off base");
    a_ser_excl: assert property (!(ser_ones && ser_zeros)) else $error("one and zero together");
    a_ser_on_base: assert property ($rose(ser_ones || ser_zeros) |-> s_base)
        else $error("serial bit off base");
    a_intr_single: assert property (@(posedge chan_clk) disable iff (rst) interrupt |=> !interrupt)
        else $error("interrupt too long");
    a_intr_status: assert property (@(posedge chan_clk) disable iff (rst) interrupt |-> in_info[29])
        else $error("no status with interrupt");
endmodule // tfa_checker
bind tfa_format_adapter tfa_checker #(.PULSE_W(PULSE_W)) u_chk (.clk, .rst, .chan_clk,
    .timing, .demand_in, .ser_ones, .ser_zeros, .interrupt, .in_info);
`default_nettype wire

// [testbench/tfa_format_adapter_tb_top.sv]
// Purpose: self-checking bench of the format adapter
// Assumes: unit 2 addressed one-hot; long frame shortened to 2
// Notes:   host on 32 ns chan_clk, tape side on 25 ns clk
`timescale 1ns/1ps
`default_nettype none
module tfa_format_adapter_tb_top;
    logic clk = 0, rst = 1, chan_clk = 0, ext_func = 0, out_ack = 0, in_ack = 0;
    logic [29:0] out_info = '0, in_info, got;
    logic [6:0] demand_in, ones, nrdy;
    logic [3:0] tape_instr;
    logic out_data_req, in_data_req, interrupt, demand_clear, master_clear, ser_ones, ser_zeros;
    tfa_pkg::tfa_timing_s timing;
    int bad_count = 0, n_tests = 0, k;
    initial forever #12.5 clk = ~clk;
    initial forever #16 chan_clk = ~chan_clk;
    tfa_tape_model tape (.clk(clk), .ones(ones), .not_ready(nrdy));
    tfa_format_adapter #(.LONG_FRAMES(2)) dut (.clk(clk), .rst(rst), .chan_clk(chan_clk),
        .out_info(out_info), .ext_func(ext_func), .out_ack(out_ack), .out_data_req(out_data_req),
        .in_info(in_info), .in_data_req(in_data_req), .in_ack(in_ack), .interrupt(interrupt),
        .tape_ones_in(ones), .tape_not_ready(nrdy), .timing(timing), .tape_instr(tape_instr),
        .demand_in(demand_in), .demand_clear(demand_clear), .master_clear(master_clear),
        .ser_ones(ser_ones), .ser_zeros(ser_zeros));
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // one host word, function or data, held for one chan cycle
    task automatic host_put(input logic [29:0] w, input logic fn);
        @(negedge chan_clk);
        out_info = w; ext_func = fn; out_ack = !fn;
        @(negedge chan_clk);
        ext_func = 0; out_ack = 0;
        repeat (12) @(negedge chan_clk);
    endtask
    // unit 2 selected, instruction 5, given operation
    function automatic logic [29:0] fword(input logic [1:0] op);
        return {17'h0, op, 7'h04, 4'h5};
    endfunction
    task automatic t_select();
        host_put(fword(2'h0), 1'b1);
        for (k = 0; k < 400 && demand_in == 7'h00; k++) @(negedge clk);
        check(demand_in, 7'h04);
        check(tape_instr, 4'h5);
        check({master_clear, demand_clear}, 2'h0);
    endtask
    task automatic t_gate();
        tape.nr_pulse(0);
        for (k = 0; k < 80 && interrupt !== 1'b1; k++) @(negedge chan_clk);
        check(interrupt, 1'b0);
        fork tape.nr_pulse(2); join_none
        for (k = 0; k < 200 && interrupt !== 1'b1; k++) @(negedge chan_clk);
        check({interrupt, in_info[6:0]}, {1'b1, 7'h04});
    endtask
    // word goes out as 30 serial pulses, MSB first
    task automatic t_write();
        host_put(fword(2'h2), 1'b1);
        for (k = 0; k < 400 && out_data_req !== 1'b1; k++) @(negedge chan_clk);
        check(out_data_req, 1'b1);
        host_put(30'h2D5AC3F1, 1'b0);
        for (int i = 29; i >= 0; i--) begin
            for (k = 0; k < 4000 && !(ser_ones | ser_zeros); k++) @(negedge clk);
            got[i] = ser_ones;
            while (ser_ones | ser_zeros) @(negedge clk);
        end
        check(got, 30'h2D5AC3F1);
        check(in_data_req, 1'b0);
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst = 0;
        repeat (4) @(negedge chan_clk);
        t_select();
        t_gate();
        t_write();
        report_and_stop();
    end
    initial begin
        #1000000;
        bad_count++;
        report_and_stop();
    end
endmodule // tfa_format_adapter_tb_top
`default_nettype wire
